// File: design/dtpwm_defs.svh
// Register indices, field positions and reset values
// for the dual timer modulated output block. Included by design files.
`ifndef DTPWM_DEFS_SVH
`define DTPWM_DEFS_SVH

// Word indices; byte address is four times the index
`define DTPWM_IDX_PSC 10'h084
`define DTPWM_IDX_FN 10'h085
`define DTPWM_IDX_CTL 10'h086
`define DTPWM_IDX_DZ 10'h087
`define DTPWM_IDX_CMP0_LO 10'h088
`define DTPWM_IDX_CMP0_HI 10'h089
`define DTPWM_IDX_CNT0_LO 10'h08a
`define DTPWM_IDX_CNT0_HI 10'h08b
`define DTPWM_IDX_CMP1_LO 10'h08c
`define DTPWM_IDX_CMP1_HI 10'h08d
`define DTPWM_IDX_CNT1_LO 10'h08e
`define DTPWM_IDX_CNT1_HI 10'h08f
`define DTPWM_IDX_ISTAT 10'h090
`define DTPWM_IDX_IMASK 10'h091
`define DTPWM_IDX_STAT 10'h092

// Control register bits
`define DTPWM_CTL_RUN0 0
`define DTPWM_CTL_RELOAD0 1
`define DTPWM_CTL_INV0 2
`define DTPWM_CTL_COMPL 3
`define DTPWM_CTL_RUN1 4
`define DTPWM_CTL_RELOAD1 5
`define DTPWM_CTL_INV1 6

// Function and divisor register fields
`define DTPWM_FN_PRI_LSB 0
`define DTPWM_FN_SEC_LSB 2
`define DTPWM_FN_DIV0_LSB 4
`define DTPWM_FN_DIV1_LSB 6

// Reset values
`define DTPWM_RST_BYTE 8'h00
`define DTPWM_RST_HALF 16'h0000
`define DTPWM_RST_DATA 32'h0000_0000

`endif

// File: design/dtpwm_pkg.sv
// Types shared by the dual timer modulated output block.
// Assumes the constants header is included by each user.
package dtpwm_pkg;
   typedef enum logic [1:0] {
      DTPWM_T_IDLE = 2'b01,
      DTPWM_T_RUN = 2'b10
   } dtpwm_tstate_t;

   typedef enum logic [1:0] {
      DTPWM_PIN_ALT0 = 2'b00,
      DTPWM_PIN_ALT1 = 2'b01,
      DTPWM_PIN_TIMER = 2'b10,
      DTPWM_PIN_CLOCK = 2'b11
   } dtpwm_pinfn_t;
endpackage

// File: design/dtpwm_tmr_if.sv
// Carrier between the register block and one down-counting timer.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
interface dtpwm_tmr_if;
   logic start;
   logic reload;
   logic invert;
   logic [1:0] div_sel;
   logic base_tick;
   logic [15:0] cnt_buf;
   logic [15:0] cmp_buf;
   logic level;
   logic zero_evt;
   logic running;
   modport ctl (output start, reload, invert, div_sel, base_tick, cnt_buf, cmp_buf,
      input level, zero_evt, running);
   modport tmr (input start, reload, invert, div_sel, base_tick, cnt_buf, cmp_buf,
      output level, zero_evt, running);
endinterface

// File: design/dtpwm_timer.sv
// One 16-bit down-counting timer with compare and terminal count.
// Assumes a one-cycle base tick from the shared prescaler.
`timescale 1ns/1ps
module dtpwm_timer (
   input wire logic pclk,
   input wire logic presetn,
   dtpwm_tmr_if.tmr t
);
   import dtpwm_pkg::*;
   `include "dtpwm_defs.svh"

   dtpwm_tstate_t st_r;
   logic [2:0] div_r;
   logic [2:0] div_mask;
   logic [15:0] cnt_r;
   logic [15:0] cmp_r;
   logic [15:0] cnt_dec;
   logic out_r;
   logic start_q_r;
   logic zero_r;
   logic tick;
   logic raw;

   always_comb begin
      unique case (t.div_sel) // R10
         2'b00: div_mask = 3'b000;
         2'b01: div_mask = 3'b001;
         2'b10: div_mask = 3'b011;
         2'b11: div_mask = 3'b111;
      endcase
   end
   assign tick = t.base_tick && ((div_r & div_mask) == div_mask); // R10
   assign cnt_dec = cnt_r - 16'h0001;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 3'b000;
      end else if (t.base_tick) begin
         div_r <= div_r + 3'b001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q_r <= 1'b0;
      end else begin
         start_q_r <= t.start;
      end
   end

   // Buffers are sampled only at load, so host writes land next period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= DTPWM_T_IDLE; // R16
         cnt_r <= `DTPWM_RST_HALF;
         cmp_r <= `DTPWM_RST_HALF;
         out_r <= 1'b0;
         zero_r <= 1'b0;
      end else begin
         zero_r <= 1'b0;
         unique case (st_r)
            DTPWM_T_IDLE: begin
               if (t.start && !start_q_r) begin
                  cnt_r <= t.cnt_buf; // R3
                  cmp_r <= t.cmp_buf;
                  out_r <= 1'b0;
                  st_r <= DTPWM_T_RUN;
               end
            end
            DTPWM_T_RUN: begin
               if (!t.start) begin
                  st_r <= DTPWM_T_IDLE;
               end else if (tick) begin
                  if (cnt_r == 16'h0000) begin
                     zero_r <= 1'b1; // R5
                     out_r <= 1'b0; // R5
                     if (t.reload) begin
                        cnt_r <= t.cnt_buf; // R7 R8
                        cmp_r <= t.cmp_buf; // R8
                     end else begin
                        st_r <= DTPWM_T_IDLE; // R7
                     end
                  end else begin
                     cnt_r <= cnt_dec; // R3
                     if (cnt_dec == cmp_r) begin
                        out_r <= 1'b1; // R4 R6
                     end
                  end
               end
            end
         endcase
      end
   end

   // Stopped without reload: static level from counter against compare
   assign raw = (st_r == DTPWM_T_IDLE && !t.reload) ? (cnt_r < t.cmp_buf) : out_r; // R11
   assign t.level = raw ^ t.invert; // R11
   assign t.zero_evt = zero_r;
   assign t.running = (st_r == DTPWM_T_RUN);

   property p_load;
      @(posedge pclk) disable iff (!presetn)
      (st_r == DTPWM_T_IDLE && t.start && !start_q_r) |=> (cnt_r == $past(t.cnt_buf));
   endproperty
   a_load: assert property (p_load) else $error("counter not loaded from buffer"); // R3

   property p_match;
      @(posedge pclk) disable iff (!presetn)
      (st_r == DTPWM_T_RUN && t.start && tick && cnt_r != 16'h0000 && cnt_dec == cmp_r)
         |=> out_r;
   endproperty
   a_match: assert property (p_match) else $error("compare match did not set output"); // R4

   sequence s_terminal;
      st_r == DTPWM_T_RUN && t.start && tick && cnt_r == 16'h0000;
   endsequence
   property p_terminal;
      @(posedge pclk) disable iff (!presetn)
      s_terminal |=> (zero_r && !out_r);
   endproperty
   a_terminal: assert property (p_terminal) else $error("terminal count missed"); // R5

   property p_noreload;
      @(posedge pclk) disable iff (!presetn)
      (s_terminal and !t.reload) |=> (st_r == DTPWM_T_IDLE) ##1 (st_r == DTPWM_T_IDLE);
   endproperty
   a_noreload: assert property (p_noreload) else $error("timer kept running"); // R7

   property p_step;
      @(posedge pclk) disable iff (!presetn)
      (st_r == DTPWM_T_RUN && t.start && !tick) |=> $stable(cnt_r);
   endproperty
   a_step: assert property (p_step) else $error("counter moved without a tick"); // R10
endmodule // dtpwm_timer

// File: design/dtpwm_top.sv
// Dual timer modulated output block with APB register slave.
// Assumes APB master on pclk; pin alternates come in as plain inputs.
`timescale 1ns/1ps
// What this block does
// R1 - Two independent 16-bit down counters drive the primary and secondary outputs.
// R2 - The host programs the first count and compare buffers before enabling modulation.
// R3 - On enable the counter loads the count buffer and then steps down once per timer tick.
// R4 - When the counter equals the compare value the output flips to its active level.
// R5 - At zero the timer raises an interrupt, restores the output and reloads the counter.
// R6 - The compare value sets the duty cycle, its sense depending on the initial level.
// R7 - Reload at zero happens only while the auto-reload control bit is set.
// R8 - Buffer values written during a period take effect from the next period.
// R9 - The base timer tick is the core clock divided by the prescaler value plus one.
// R10 - Each timer further divides by 1, 2, 4 or 8 as chosen in the function register.
// R11 - Stopped without reload, the output is high below compare and low above, with inversion.
// R12 - The primary pin shows the GPIO level, the first timer or the core clock.
// R13 - The secondary pin shows the error flag, a timer output or the oscillator clock.
// R14 - Complementary mode drives the secondary as the primary's inverse with a dead zone.
// R15 - The second timer behaves as the first with its own buffers and divisor.
// R16 - After reset both counters stop and both outputs rest at their inactive level; the code instead passes the GPIO level and error flag to them.
module dtpwm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic gpio_level,
   input wire logic sys_error,
   input wire logic core_clk_mirror,
   input wire logic osc_clk_mirror,
   output logic primary_modulated_output,
   output logic secondary_modulated_output,
   output logic irq
);
   import dtpwm_pkg::*;
   `include "dtpwm_defs.svh"

   logic [7:0] psc_r;
   logic [7:0] fn_r;
   logic [7:0] ctl_r;
   logic [7:0] dz_r;
   logic [15:0] first_compare_buffer_r;
   logic [15:0] first_count_buffer_r;
   logic [15:0] cmp1_r;
   logic [15:0] cnt1_r;
   logic [1:0] ist_r;
   logic [1:0] imask_r;
   logic [7:0] pscc_r;
   logic base_tick_r;
   logic [31:0] prdata_r;
   logic slverr_r;
   logic [31:0] rd_mux;
   logic mapped;
   logic [9:0] idx;
   logic wr_en;
   logic [7:0] wb;
   logic lvl0;
   logic lvl1;
   logic a_q_r;
   logic [7:0] dzc_r;
   logic settled;
   logic pri_r;
   logic sec_r;
   dtpwm_pinfn_t pri_fn;
   dtpwm_pinfn_t sec_fn;

   dtpwm_tmr_if t0_if ();
   dtpwm_tmr_if t1_if ();

   // APB decode; zero wait states so every access ends in one cycle
   assign idx = paddr[11:2];
   assign wb = pwdata[7:0];
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite && mapped;

   always_comb begin
      mapped = (paddr[1:0] == 2'b00);
      rd_mux = `DTPWM_RST_DATA;
      unique case (idx)
         `DTPWM_IDX_PSC: rd_mux[7:0] = psc_r;
         `DTPWM_IDX_FN: rd_mux[7:0] = fn_r;
         `DTPWM_IDX_CTL: rd_mux[7:0] = ctl_r;
         `DTPWM_IDX_DZ: rd_mux[7:0] = dz_r;
         `DTPWM_IDX_CMP0_LO: rd_mux[7:0] = first_compare_buffer_r[7:0];
         `DTPWM_IDX_CMP0_HI: rd_mux[7:0] = first_compare_buffer_r[15:8];
         `DTPWM_IDX_CNT0_LO: rd_mux[7:0] = first_count_buffer_r[7:0];
         `DTPWM_IDX_CNT0_HI: rd_mux[7:0] = first_count_buffer_r[15:8];
         `DTPWM_IDX_CMP1_LO: rd_mux[7:0] = cmp1_r[7:0];
         `DTPWM_IDX_CMP1_HI: rd_mux[7:0] = cmp1_r[15:8];
         `DTPWM_IDX_CNT1_LO: rd_mux[7:0] = cnt1_r[7:0];
         `DTPWM_IDX_CNT1_HI: rd_mux[7:0] = cnt1_r[15:8];
         `DTPWM_IDX_ISTAT: rd_mux[1:0] = ist_r;
         `DTPWM_IDX_IMASK: rd_mux[1:0] = imask_r;
         `DTPWM_IDX_STAT: rd_mux[3:0] = {t1_if.running, t0_if.running, lvl1, lvl0};
         default: mapped = 1'b0;
      endcase
   end

   // Read data captured in the setup cycle, held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `DTPWM_RST_DATA;
         slverr_r <= 1'b0;
      end else if (psel && !penable) begin
         prdata_r <= (pwrite || !mapped) ? `DTPWM_RST_DATA : rd_mux;
         slverr_r <= !mapped;
      end
   end
   assign prdata = prdata_r;
   assign pslverr = slverr_r && psel && penable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_r <= `DTPWM_RST_BYTE;
         fn_r <= `DTPWM_RST_BYTE;
         ctl_r <= `DTPWM_RST_BYTE; // R16
         dz_r <= `DTPWM_RST_BYTE;
         first_compare_buffer_r <= `DTPWM_RST_HALF;
         first_count_buffer_r <= `DTPWM_RST_HALF;
         cmp1_r <= `DTPWM_RST_HALF;
         cnt1_r <= `DTPWM_RST_HALF;
         imask_r <= 2'b00;
      end else if (wr_en) begin
         unique case (idx)
            `DTPWM_IDX_PSC: psc_r <= wb;
            `DTPWM_IDX_FN: fn_r <= wb;
            `DTPWM_IDX_CTL: ctl_r <= wb;
            `DTPWM_IDX_DZ: dz_r <= wb;
            `DTPWM_IDX_CMP0_LO: first_compare_buffer_r[7:0] <= wb; // R2 R8
            `DTPWM_IDX_CMP0_HI: first_compare_buffer_r[15:8] <= wb; // R2 R8
            `DTPWM_IDX_CNT0_LO: first_count_buffer_r[7:0] <= wb; // R2 R8
            `DTPWM_IDX_CNT0_HI: first_count_buffer_r[15:8] <= wb; // R2 R8
            `DTPWM_IDX_CMP1_LO: cmp1_r[7:0] <= wb; // R15
            `DTPWM_IDX_CMP1_HI: cmp1_r[15:8] <= wb;
            `DTPWM_IDX_CNT1_LO: cnt1_r[7:0] <= wb;
            `DTPWM_IDX_CNT1_HI: cnt1_r[15:8] <= wb;
            `DTPWM_IDX_IMASK: imask_r <= wb[1:0];
            default: ;
         endcase
      end
   end

   // Sticky status; a terminal count in the clearing cycle still sets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_r <= 2'b00;
      end else begin
         ist_r <= (ist_r & ~((wr_en && idx == `DTPWM_IDX_ISTAT) ? wb[1:0] : 2'b00))
            | {t1_if.zero_evt, t0_if.zero_evt}; // R5
      end
   end
   assign irq = |(ist_r & imask_r);

   // Shared prescaler: one base tick every psc+1 clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pscc_r <= 8'h00;
         base_tick_r <= 1'b0;
      end else if (pscc_r >= psc_r) begin
         pscc_r <= 8'h00; // R9
         base_tick_r <= 1'b1; // R9
      end else begin
         pscc_r <= pscc_r + 8'h01;
         base_tick_r <= 1'b0;
      end
   end

   assign t0_if.start = ctl_r[`DTPWM_CTL_RUN0];
   assign t0_if.reload = ctl_r[`DTPWM_CTL_RELOAD0]; // R7
   assign t0_if.invert = ctl_r[`DTPWM_CTL_INV0]; // R11
   assign t0_if.div_sel = fn_r[`DTPWM_FN_DIV0_LSB +: 2]; // R10
   assign t0_if.base_tick = base_tick_r;
   assign t0_if.cnt_buf = first_count_buffer_r;
   assign t0_if.cmp_buf = first_compare_buffer_r;
   assign t1_if.start = ctl_r[`DTPWM_CTL_RUN1]; // R15
   assign t1_if.reload = ctl_r[`DTPWM_CTL_RELOAD1];
   assign t1_if.invert = ctl_r[`DTPWM_CTL_INV1];
   assign t1_if.div_sel = fn_r[`DTPWM_FN_DIV1_LSB +: 2];
   assign t1_if.base_tick = base_tick_r;
   assign t1_if.cnt_buf = cnt1_r;
   assign t1_if.cmp_buf = cmp1_r;

   dtpwm_timer u_timer0 ( // R1
      .pclk(pclk),
      .presetn(presetn),
      .t(t0_if.tmr)
   );
   dtpwm_timer u_timer1 ( // R1 R15
      .pclk(pclk),
      .presetn(presetn),
      .t(t1_if.tmr)
   );

   assign lvl0 = t0_if.level;
   assign lvl1 = t1_if.level;

   // Dead zone: both pins rest low for dz_r clocks after each edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_q_r <= 1'b0;
         dzc_r <= 8'h00;
      end else begin
         a_q_r <= lvl0;
         if (lvl0 != a_q_r) begin
            dzc_r <= 8'h00; // R14
         end else if (dzc_r != 8'hff) begin
            dzc_r <= dzc_r + 8'h01;
         end
      end
   end
   // Counter lags the edge by one clock, so compare against dz_r less one
   assign settled = (dz_r == 8'h00)
      || ((lvl0 == a_q_r) && (({1'b0, dzc_r} + 9'h001) >= {1'b0, dz_r})); // R14

   assign pri_fn = dtpwm_pinfn_t'(fn_r[`DTPWM_FN_PRI_LSB +: 2]);
   assign sec_fn = dtpwm_pinfn_t'(fn_r[`DTPWM_FN_SEC_LSB +: 2]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pri_r <= 1'b0; // R16
         sec_r <= 1'b0; // R16
      end else begin
         if (pri_fn == DTPWM_PIN_TIMER) begin
            pri_r <= ctl_r[`DTPWM_CTL_COMPL] ? (lvl0 && settled) : lvl0; // R12 R14
         end else begin
            pri_r <= gpio_level; // R12
         end
         if (sec_fn == DTPWM_PIN_TIMER) begin
            sec_r <= ctl_r[`DTPWM_CTL_COMPL] ? (!lvl0 && settled) : lvl1; // R13 R14
         end else begin
            sec_r <= sys_error; // R13
         end
      end
   end

   // Clock alternates bypass the flops; a flop would halve them
   assign primary_modulated_output = (pri_fn == DTPWM_PIN_CLOCK) ? core_clk_mirror : pri_r; // R12
   assign secondary_modulated_output = (sec_fn == DTPWM_PIN_CLOCK) ? osc_clk_mirror : sec_r; // R13

   property p_psc1;
      @(posedge pclk) disable iff (!presetn)
      (base_tick_r && psc_r == 8'h01 && $stable(psc_r)) |=> !base_tick_r ##1 base_tick_r;
   endproperty
   a_psc1: assert property (p_psc1) else $error("prescaler period wrong"); // R9

   property p_psc0;
      @(posedge pclk) disable iff (!presetn)
      (psc_r == 8'h00 && $past(psc_r) == 8'h00 && pscc_r == 8'h00) |=> base_tick_r;
   endproperty
   a_psc0: assert property (p_psc0) else $error("undivided prescaler skipped a tick"); // R9

   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      (t1_if.zero_evt && imask_r[1]) |=> (irq || !imask_r[1]);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt output mismatch"); // R5

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
      t0_if.zero_evt |=> ist_r[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("terminal event lost"); // R5

   property p_compl;
      @(posedge pclk) disable iff (!presetn)
      (sec_fn == DTPWM_PIN_TIMER && pri_fn == DTPWM_PIN_TIMER && ctl_r[`DTPWM_CTL_COMPL])
         |-> !(pri_r && sec_r);
   endproperty
   a_compl: assert property (p_compl) else $error("complementary pins overlap"); // R14

   property p_dz;
      @(posedge pclk) disable iff (!presetn)
      (dz_r == 8'h02 && $stable(dz_r) && lvl0 != a_q_r && ctl_r[`DTPWM_CTL_COMPL]
         && pri_fn == DTPWM_PIN_TIMER) |=> !pri_r [*2];
   endproperty
   a_dz: assert property (p_dz) else $error("dead zone too short"); // R14

   property p_gpio;
      @(posedge pclk) disable iff (!presetn)
      (pri_fn == DTPWM_PIN_ALT0 && $past(pri_fn) == DTPWM_PIN_ALT0)
         |-> (primary_modulated_output == $past(gpio_level));
   endproperty
   a_gpio: assert property (p_gpio) else $error("primary pin not on gpio level"); // R12
endmodule // dtpwm_top

// File: verif/dtpwm_host.sv
// APB master model standing in for the host microcontroller.
// Assumes the slave samples on rising pclk; one transfer at a time.
`timescale 1ns/1ps
module dtpwm_host (
   input wire logic pclk,
   input wire logic pready,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // Request held until pready seen high at a rising edge
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [7:0] data);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= {24'h00_0000, data};
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle limit here; only the bench watchdog ends a stuck wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines must not keep showing the old request
      paddr <= ~addr;
      pwdata <= ~{24'h00_0000, data};
   endtask
endmodule // dtpwm_host

// File: verif/dtpwm_top_test.sv
// Self-checking bench for the dual timer modulated output block.
// Assumes the host model drives APB; reads are judged by a monitor.
`timescale 1ns/1ps
`include "dtpwm_defs.svh"
module dtpwm_top_test;
   import dtpwm_pkg::*;
   typedef struct {string nm; logic [32:0] v;} dtpwm_note_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic gpio_level = 1'b0;
   logic sys_error = 1'b0;
   logic core_clk_mirror = 1'b0;
   logic osc_clk_mirror = 1'b0;
   logic primary_modulated_output, secondary_modulated_output;
   integer seed = 32'h3a99a975;
   int fail_count = 0;
   int checks_done = 0;
   int p, s, both;
   dtpwm_note_t notes[$];
   dtpwm_note_t note;
   logic [7:0] d;
   logic [9:0] rw_list [11] = '{`DTPWM_IDX_PSC, `DTPWM_IDX_FN, `DTPWM_IDX_DZ,
      `DTPWM_IDX_CMP0_LO, `DTPWM_IDX_CMP0_HI, `DTPWM_IDX_CNT0_LO, `DTPWM_IDX_CNT0_HI,
      `DTPWM_IDX_CMP1_LO, `DTPWM_IDX_CMP1_HI, `DTPWM_IDX_CNT1_LO, `DTPWM_IDX_IMASK};

   always #5 pclk = ~pclk;

   dtpwm_host i_dtpwm_host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   dtpwm_top i_dtpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gpio_level(gpio_level), .sys_error(sys_error),
      .core_clk_mirror(core_clk_mirror), .osc_clk_mirror(osc_clk_mirror),
      .primary_modulated_output(primary_modulated_output),
      .secondary_modulated_output(secondary_modulated_output), .irq(irq));

   // Mirrored clocks take a new random value every cycle so a stuck pass-through shows
   always @(posedge pclk) begin
      core_clk_mirror <= $random(seed);
      osc_clk_mirror <= $random(seed);
   end

   task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Read results taken at the access edge, oldest note first
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         if (notes.size() == 0) begin
            fail_count++;
            $display("unexpected read: expected none seen %h", prdata);
         end else begin
            note = notes.pop_front();
            check(note.nm, {pslverr, prdata}, note.v);
         end
      end
   end

   task automatic wr(input logic [9:0] idx, input logic [7:0] v);
      i_dtpwm_host.xfer(1'b1, {idx, 2'b00}, v);
   endtask

   task automatic rda(input logic [11:0] a, input logic [32:0] exp, input string nm);
      notes.push_back('{nm, exp});
      i_dtpwm_host.xfer(1'b0, a, 8'h00);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [32:0] exp, input string nm);
      rda({idx, 2'b00}, exp, nm);
   endtask

   task automatic wr16(input logic [9:0] lo, input logic [15:0] v);
      wr(lo, v[7:0]);
      wr(lo + 10'h001, v[15:8]);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   // Counts high cycles of each pin and cycles where both are high
   task automatic sample(input int n, output int hp, output int hs, output int hb);
      hp = 0;
      hs = 0;
      hb = 0;
      repeat (n) begin
         wait_cyc(1);
         hp += (primary_modulated_output === 1'b1);
         hs += (secondary_modulated_output === 1'b1);
         hb += (primary_modulated_output === 1'b1 && secondary_modulated_output === 1'b1);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Whole run is about 1600 cycles of the 20000 allowed; this is ample margin
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      wait_cyc(1);
      check("primary at reset", 33'(primary_modulated_output), 33'h0_0000_0000);
      check("secondary at reset", 33'(secondary_modulated_output), 33'h0_0000_0000);
      check("irq at reset", 33'(irq), 33'h0_0000_0000);
      for (int i = `DTPWM_IDX_PSC; i <= `DTPWM_IDX_STAT; i++) begin
         rd(10'(i), 33'h0_0000_0000, "reset value");
      end
      wr(`DTPWM_IDX_STAT, 8'hff);
      rd(`DTPWM_IDX_STAT, 33'h0_0000_0000, "status after write");
      rd(10'h093, 33'h1_0000_0000, "unmapped read");
      $display("test reset done");

      foreach (rw_list[i]) begin
         d = 8'($random(seed));
         wr(rw_list[i], d);
         // Mask register keeps only the two event bits
         if (rw_list[i] == `DTPWM_IDX_IMASK) d = d & 8'h03;
         rd(rw_list[i], {25'h000_0000, d}, "readback");
      end
      $display("test registers done");

      // Stopped, no reload: fixed level from counter against compare
      wr(`DTPWM_IDX_PSC, 8'h00);
      wr(`DTPWM_IDX_FN, 8'h02);
      wr16(`DTPWM_IDX_CMP0_LO, 16'h0005);
      wr(`DTPWM_IDX_CTL, 8'h00);
      wait_cyc(3);
      check("static level", 33'(primary_modulated_output), 33'h0_0000_0001);
      wr(`DTPWM_IDX_CTL, 8'h04);
      wait_cyc(3);
      check("static inverted", 33'(primary_modulated_output), 33'h0_0000_0000);
      $display("test static done");

      // Tick every 2*4 clocks, period 5 ticks, high cmp+1 ticks
      wr(`DTPWM_IDX_PSC, 8'h01);
      rda(12'h211, 33'h1_0000_0000, "misaligned read");
      wr(`DTPWM_IDX_FN, 8'h22);
      wr16(`DTPWM_IDX_CMP0_LO, 16'h0002);
      wr16(`DTPWM_IDX_CNT0_LO, 16'h0004);
      wr(`DTPWM_IDX_IMASK, 8'h00);
      wr(`DTPWM_IDX_CTL, 8'h03);
      wait_cyc(60);
      sample(200, p, s, both);
      check("timer0 high count", 33'(p), 33'd120);
      check("irq masked", 33'(irq), 33'h0_0000_0000);
      rd(`DTPWM_IDX_ISTAT, 33'h0_0000_0001, "zero status");
      wr(`DTPWM_IDX_IMASK, 8'h01);
      wait_cyc(2);
      check("irq unmasked", 33'(irq), 33'h0_0000_0001);
      wr16(`DTPWM_IDX_CMP0_LO, 16'h0000);
      wait_cyc(60);
      sample(200, p, s, both);
      check("new duty", 33'(p), 33'd40);
      wr(`DTPWM_IDX_CTL, 8'h00);
      wait_cyc(10);
      wr(`DTPWM_IDX_ISTAT, 8'h01);
      wait_cyc(2);
      check("irq cleared", 33'(irq), 33'h0_0000_0000);
      rd(`DTPWM_IDX_ISTAT, 33'h0_0000_0000, "status cleared");
      // One-shot: runs to zero once, then stays idle
      wr(`DTPWM_IDX_CTL, 8'h01);
      wait_cyc(60);
      rd(`DTPWM_IDX_ISTAT, 33'h0_0000_0001, "one-shot zero");
      wr(`DTPWM_IDX_ISTAT, 8'h01);
      wait_cyc(60);
      rd(`DTPWM_IDX_ISTAT, 33'h0_0000_0000, "no reload");
      $display("test timer0 done");

      // Second timer: tick every 2*2 clocks, period 4 ticks
      wr(`DTPWM_IDX_FN, 8'h48);
      wr16(`DTPWM_IDX_CMP1_LO, 16'h0000);
      wr16(`DTPWM_IDX_CNT1_LO, 16'h0003);
      wr(`DTPWM_IDX_IMASK, 8'h02);
      wr(`DTPWM_IDX_CTL, 8'h30);
      wait_cyc(40);
      sample(160, p, s, both);
      check("timer1 high count", 33'(s), 33'd40);
      check("timer1 irq", 33'(irq), 33'h0_0000_0001);
      wr(`DTPWM_IDX_CTL, 8'h70);
      wait_cyc(40);
      sample(160, p, s, both);
      check("timer1 inverted", 33'(s), 33'd120);
      wr(`DTPWM_IDX_CTL, 8'h00);
      wait_cyc(10);
      wr(`DTPWM_IDX_ISTAT, 8'h03);
      $display("test timer1 done");

      wr(`DTPWM_IDX_FN, 8'h00);
      repeat (4) begin
         @(posedge pclk);
         gpio_level <= $random(seed);
         sys_error <= $random(seed);
         wait_cyc(3);
         check("primary gpio", 33'(primary_modulated_output), 33'(gpio_level));
         check("secondary error", 33'(secondary_modulated_output), 33'(sys_error));
      end
      wr(`DTPWM_IDX_FN, 8'h0f);
      repeat (4) begin
         wait_cyc(1);
         check("primary clock", 33'(primary_modulated_output), 33'(core_clk_mirror));
         check("secondary clock", 33'(secondary_modulated_output), 33'(osc_clk_mirror));
      end
      $display("test pin functions done");

      // Complementary pair with dead zone: never both high
      wr(`DTPWM_IDX_FN, 8'h2a);
      wr16(`DTPWM_IDX_CMP0_LO, 16'h0002);
      wr(`DTPWM_IDX_DZ, 8'h02);
      wr(`DTPWM_IDX_CTL, 8'h0b);
      wait_cyc(60);
      sample(200, p, s, both);
      check("overlap", 33'(both), 33'h0_0000_0000);
      check("dead zone primary", 33'(p), 33'd110);
      check("dead zone secondary", 33'(s), 33'd70);
      $display("test complementary done");
      wait_cyc(4);
      end_of_test();
   end
endmodule // dtpwm_top_test
